// ===== src/gpio_ports_map.svh
// register offsets, field widths and reset values of the dual io ports
`ifndef GPIO_PORTS_MAP_SVH
`define GPIO_PORTS_MAP_SVH
`define OFS_PORT_B_DIRECTION 12'h000
`define OFS_PORT_D_DIRECTION 12'h002
`define OFS_PORT_B_ATTRIBUTE 12'h004
`define OFS_PORT_D_ATTRIBUTE 12'h006
`define OFS_PORT_B_PIN_DATA  12'h008
`define OFS_PORT_D_PIN_DATA  12'h00A
// bus byte address, four times the register offset
`define ADDR_PORT_B_DIRECTION 12'h000
`define ADDR_PORT_D_DIRECTION 12'h008
`define ADDR_PORT_B_ATTRIBUTE 12'h010
`define ADDR_PORT_D_ATTRIBUTE 12'h018
`define ADDR_PORT_B_PIN_DATA  12'h020
`define ADDR_PORT_D_PIN_DATA  12'h028
`define PORT_PINS            6
`define REG_RESET            6'h00
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2
`endif

// ===== src/gpio_ports_pkg.sv
// types shared by the dual io ports
package gpio_ports_pkg;
  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
    logic [5:0] pull_up;
    logic [5:0] pull_down;
  } pin_drive_t;
  typedef struct packed {
    logic [5:0] dir;
    logic [5:0] att;
    logic [5:0] dat;
  } port_cfg_t;
endpackage : gpio_ports_pkg

// ===== src/dual_six_bit_io_ports.sv
// two six-bit io ports behind an axi4-lite slave
`timescale 1ns/100ps
`include "gpio_ports_map.svh"
module dual_six_bit_io_ports (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // first port pins
  input  wire logic [5:0]                port_b_i,
  output gpio_ports_pkg::pin_drive_t     port_b_drv,
  // second port pins
  input  wire logic [5:0]                port_d_i,
  output gpio_ports_pkg::pin_drive_t     port_d_drv,
  // crystal sharing: high hands bits 1:0 of the second port to the oscillator
  input  wire logic                      crystal_enable,
  output logic                           crystal_select
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  gpio_ports_pkg::port_cfg_t b_q;
  gpio_ports_pkg::port_cfg_t d_q;
  logic [11:0]               aw_q;
  logic                      aw_have_q;
  logic [31:0]               w_q;
  logic [3:0]                ws_q;
  logic                      w_have_q;
  logic [5:0]                b_s1_q;
  logic [5:0]                b_s2_q;
  logic [5:0]                d_s1_q;
  logic [5:0]                d_s2_q;
  logic                      x_s1_q;
  logic                      x_s2_q;
  logic                      do_wr;
  logic                      wr_hit;
  logic [5:0]                wr_sel;

  assign do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;

  always_comb
  begin
    wr_sel = 6'h00;
    unique case (aw_q)
      `ADDR_PORT_B_DIRECTION: wr_sel = 6'h01;
      `ADDR_PORT_D_DIRECTION: wr_sel = 6'h02;
      `ADDR_PORT_B_ATTRIBUTE: wr_sel = 6'h04;
      `ADDR_PORT_D_ATTRIBUTE: wr_sel = 6'h08;
      `ADDR_PORT_B_PIN_DATA:  wr_sel = 6'h10;
      `ADDR_PORT_D_PIN_DATA:  wr_sel = 6'h20;
      default:                wr_sel = 6'h00;
    endcase
  end

  assign wr_hit = |wr_sel;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      b_q <= {3{`REG_RESET}};
    end
    else if (do_wr && ws_q[0])
    begin
      if (wr_sel[0])
      begin
        b_q.dir <= w_q[5:0];
      end
      if (wr_sel[2])
      begin
        b_q.att <= w_q[5:0];
      end
      if (wr_sel[4])
      begin
        b_q.dat <= w_q[5:0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      d_q <= {3{`REG_RESET}};
    end
    else if (do_wr && ws_q[0])
    begin
      if (wr_sel[1])
      begin
        d_q.dir <= w_q[5:0];
      end
      if (wr_sel[3])
      begin
        d_q.att <= w_q[5:0];
      end
      if (wr_sel[5])
      begin
        d_q.dat <= w_q[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      aw_q          <= 12'h000;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q      <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q     <= 1'b0;
      w_q          <= 32'h0000_0000;
      ws_q         <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (do_wr)
      begin
        w_have_q <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      b_s1_q <= 6'h00;
      b_s2_q <= 6'h00;
      d_s1_q <= 6'h00;
      d_s2_q <= 6'h00;
      x_s1_q <= 1'b0;
      x_s2_q <= 1'b0;
    end
    else
    begin
      b_s1_q <= port_b_i;
      b_s2_q <= b_s1_q;
      d_s1_q <= port_d_i;
      d_s2_q <= d_s1_q;
      x_s1_q <= crystal_enable;
      x_s2_q <= x_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_RESP_OKAY;
      unique case (s_axi_araddr)
        `ADDR_PORT_B_DIRECTION: s_axi_rdata <= {26'h0, b_q.dir};
        `ADDR_PORT_D_DIRECTION: s_axi_rdata <= {26'h0, d_q.dir};
        `ADDR_PORT_B_ATTRIBUTE: s_axi_rdata <= {26'h0, b_q.att};
        `ADDR_PORT_D_ATTRIBUTE: s_axi_rdata <= {26'h0, d_q.att};
        `ADDR_PORT_B_PIN_DATA:  s_axi_rdata <= {26'h0, b_s2_q};
        `ADDR_PORT_D_PIN_DATA:  s_axi_rdata <= {26'h0, d_s2_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AXI_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_b_drv     <= '0;
      port_d_drv     <= '0;
      crystal_select <= 1'b0;
    end
    else
    begin
      crystal_select       <= x_s2_q;
      port_b_drv.oe        <= b_q.dir;
      port_b_drv.o         <= b_q.dat ^ b_q.att;
      port_b_drv.pull_up   <= ~b_q.dir & b_q.dat & b_q.att;
      port_b_drv.pull_down <= ~b_q.dir & b_q.dat & ~b_q.att;
      port_d_drv.oe        <= d_q.dir;
      port_d_drv.o         <= d_q.dat ^ d_q.att;
      port_d_drv.pull_up   <= ~d_q.dir & d_q.dat & d_q.att;
      port_d_drv.pull_down <= ~d_q.dir & d_q.dat & ~d_q.att;
      if (x_s2_q)
      begin
        port_d_drv.oe[1:0]        <= 2'h0;
        port_d_drv.pull_up[1:0]   <= 2'h0;
        port_d_drv.pull_down[1:0] <= 2'h0;
      end
    end
  end

endmodule : dual_six_bit_io_ports

// ===== test/io_ports_chk.sv
// checker on the io port bus handshakes and pin drive
`timescale 1ns/100ps
module io_ports_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pins
  input wire gpio_ports_pkg::pin_drive_t port_b_drv,
  input wire gpio_ports_pkg::pin_drive_t port_d_drv,
  input wire logic crystal_enable,
  input wire logic crystal_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> port_b_drv == '0 && port_d_drv == '0)
    else $error("pins not released after reset");
  a_oe_no_pull: assert property ((port_b_drv.oe & (port_b_drv.pull_up | port_b_drv.pull_down)) == 6'h00)
    else $error("pull active on a driven pin");
  a_pull_excl: assert property ((port_d_drv.pull_up & port_d_drv.pull_down) == 6'h00)
    else $error("pull up and pull down together");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rv_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("upper read bits set");
  a_xtal_on: assert property (crystal_enable [*5] |-> crystal_select)
    else $error("crystal not selected");
  a_xtal_pins: assert property (crystal_select |-> (port_d_drv.oe[1:0] | port_d_drv.pull_up[1:0]) == 2'h0)
    else $error("crystal pins still driven");
  c_read: cover property (s_axi_arvalid && s_axi_arready);
  c_write: cover property (s_axi_awready && s_axi_wready);
  c_xtal: cover property (crystal_select);
endmodule : io_ports_chk

// ===== test/pin_model.sv
// external pins: driven outputs first, then keys where enabled, pulls otherwise, drift when floating
`timescale 1ns/100ps
module pin_model (
  input wire logic aclk,
  input wire gpio_ports_pkg::pin_drive_t drv,
  input wire logic [5:0] key,
  input wire logic [5:0] key_en,
  output logic [5:0] lvl
);
  logic [5:0] drift_q = 6'h15;
  always @(posedge aclk) drift_q <= ~drift_q;
  always_comb lvl = (drv.oe & drv.o) | (~drv.oe & key_en & key)
    | (~drv.oe & ~key_en & (drv.pull_up | (~drv.pull_down & drift_q)));
endmodule : pin_model

// ===== test/testbench.sv
// self-checking bench for the dual io ports
`timescale 1ns/100ps
`include "gpio_ports_map.svh"
module testbench;
  logic aclk = 0, aresetn = 0, crystal_enable = 0, crystal_select;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_q, v;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] port_b_i, port_d_i;
  logic [5:0] key [2] = '{6'h00, 6'h00};
  logic [5:0] key_en [2] = '{6'h3F, 6'h3F};
  gpio_ports_pkg::pin_drive_t port_b_drv, port_d_drv, e;
  logic [11:0] ofs [6] = '{`ADDR_PORT_B_DIRECTION, `ADDR_PORT_D_DIRECTION, `ADDR_PORT_B_ATTRIBUTE,
    `ADDR_PORT_D_ATTRIBUTE, `ADDR_PORT_B_PIN_DATA, `ADDR_PORT_D_PIN_DATA};
  int cfg [6] = '{0, 0, 0, 0, 0, 0};
  int error_cnt = 0, num_checks = 0, k;
  always #50 aclk = ~aclk;
  dual_six_bit_io_ports dual_six_bit_io_ports_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_b_i(port_b_i), .port_b_drv(port_b_drv), .port_d_i(port_d_i), .port_d_drv(port_d_drv),
    .crystal_enable(crystal_enable), .crystal_select(crystal_select));
  pin_model pin_model_b_inst (.aclk(aclk), .drv(port_b_drv), .key(key[0]), .key_en(key_en[0]), .lvl(port_b_i));
  pin_model pin_model_d_inst (.aclk(aclk), .drv(port_d_drv), .key(key[1]), .key_en(key_en[1]), .lvl(port_d_i));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  function automatic gpio_ports_pkg::pin_drive_t exp_drv(input int p);
    logic [5:0] d, a, t, x;
    d = cfg[p][5:0];
    a = cfg[p + 2][5:0];
    t = cfg[p + 4][5:0];
    x = (p == 1 && crystal_enable) ? 6'h03 : 6'h00;
    return '{t ^ a, d & ~x, ~d & t & a & ~x, ~d & t & ~a & ~x};
  endfunction : exp_drv
  function automatic logic [5:0] exp_lvl(input int p);
    gpio_ports_pkg::pin_drive_t x;
    x = exp_drv(p);
    return (x.oe & x.o) | (~x.oe & key_en[p] & key[p]) | (~x.oe & ~key_en[p] & x.pull_up);
  endfunction : exp_lvl
  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial
  begin
    #2ms;
    error_cnt++;
    test_done();
  end
  initial
  begin
    void'($urandom(55));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 24; i++)
    begin
      crystal_enable <= (i >= 12 && i < 20);
      if (i == 16)
      begin
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cfg = '{0, 0, 0, 0, 0, 0};
      end
      k = $urandom_range(7);
      v = $urandom;
      wr((k == 6) ? 12'h00C : ofs[k % 6], v, (k == 7) ? 4'hE : 4'hF);
      chk("bresp", rsp, (k == 6) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY);
      if (k < 6) cfg[k] = v[5:0];
      repeat (2) @(posedge aclk);
      chk("drive b", port_b_drv, exp_drv(0));
      chk("drive d", port_d_drv, exp_drv(1));
      chk("xtal", crystal_select, crystal_enable);
      for (int p = 0; p < 2; p++)
      begin
        e = exp_drv(p);
        key_en[p] <= ~(e.pull_up | e.pull_down);
        key[p] <= $urandom;
      end
      repeat (4) @(posedge aclk);
      for (int j = 0; j < 6; j++)
      begin
        rd(ofs[j]);
        chk("reg", rd_q, (j < 4) ? cfg[j] : exp_lvl(j % 2));
        chk("rresp ok", rsp, `AXI_RESP_OKAY);
      end
    end
    rd(12'h00C);
    chk("rresp", rsp, `AXI_RESP_SLVERR);
    chk("rdata", rd_q, 32'h0);
    test_done();
  end
endmodule : testbench
bind dual_six_bit_io_ports io_ports_chk io_ports_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .port_b_drv(port_b_drv), .port_d_drv(port_d_drv), .crystal_enable(crystal_enable),
  .crystal_select(crystal_select));
